/* File: rtl/sense_prot_consts.svh */
// Constants for the overcurrent protection configuration block.
`ifndef SENSE_PROT_CONSTS_SVH
`define SENSE_PROT_CONSTS_SVH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_PROT_CFG 8'h1E
`define ADDR_FILT_CFG 8'h20
`define ADDR_STATUS   8'h21
`define ADDR_CLEAR    8'h22
`define ADDR_IRQ_EN   8'h23
`define ADDR_LIVE     8'h24

// ****************************************
// Reset values
// ****************************************
`define RST_PROT_CFG 16'h0833
`define RST_FILT_CFG 7'h07
`define RST_IRQ_EN   3'h0

// ****************************************
// Field positions in status, clear and enable registers
// ****************************************
`define STAT_FAULT_BIT 0
`define STAT_POS_BIT   1
`define STAT_NEG_BIT   2

// ****************************************
// Timing and counts
// ****************************************
`define CLK_PERIOD_NS 10
`define FILT_T0_NS    0
`define FILT_T1_NS    2000
`define FILT_T2_NS    4000
`define FILT_T3_NS    8000
`define FILT_T0_CYC   (`FILT_T0_NS / `CLK_PERIOD_NS)
`define FILT_T1_CYC   (`FILT_T1_NS / `CLK_PERIOD_NS)
`define FILT_T2_CYC   (`FILT_T2_NS / `CLK_PERIOD_NS)
`define FILT_T3_CYC   (`FILT_T3_NS / `CLK_PERIOD_NS)
`define FILT_CNT_W    10
`define TRIG_CNT_A    8
`define TRIG_CNT_B    16

`endif

/* File: rtl/sense_prot_pkg.sv */
// Types shared by the overcurrent protection configuration block.
`default_nettype none
`include "sense_prot_consts.svh"

package sense_prot_pkg;

    // Auto-zero operating modes.
    typedef enum logic [1:0] {
        AZ_INT_SYNC    = 2'b00,
        AZ_OFF         = 2'b01,
        AZ_EXT_SYNC    = 2'b10,
        AZ_EXT_CP_GATE = 2'b11
    } auto_zero_t;

    // Fault trigger policies.
    typedef enum logic [1:0] {
        TRIG_8    = 2'b00,
        TRIG_16   = 2'b01,
        TRIG_ALL  = 2'b10,
        TRIG_NONE = 2'b11
    } trigger_t;

    // Fault reporting states.
    typedef enum logic [1:0] {
        FLT_IDLE   = 2'b00,
        FLT_ACTIVE = 2'b01,
        FLT_HELD   = 2'b10
    } fault_state_t;

    // Protection configuration register layout, MSB first.
    typedef struct packed {
        auto_zero_t auto_zero_select;
        logic       negative_protection_disable;
        logic       reference_source_select;
        logic       truncation_disable;
        logic       brake_on_overcurrent;
        logic       rdson_sensing;
        logic       overcurrent_fault_hold;
        logic [3:0] negative_trip_level;
        logic [3:0] positive_trip_level;
    } prot_cfg_t;

    // Filter and trigger register layout, MSB first.
    typedef struct packed {
        trigger_t   overcurrent_trigger_count;
        logic [1:0] overcurrent_filter_time;
        logic [2:0] phase_enable;
    } filt_cfg_t;

    // Comparator trip inputs, one bit per phase.
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
    } trip_t;

    // Drive stage control outputs.
    typedef struct packed {
        logic fault;
        logic truncate;
        logic brake;
    } drive_ctrl_t;

    // Whole state of the top module.
    typedef struct packed {
        prot_cfg_t    cfg;
        filt_cfg_t    fcfg;
        logic [2:0]   irq_en;
        logic [2:0]   status;
        trip_t        sync1;
        trip_t        sync2;
        logic         pos_prev;
        logic         neg_prev;
        logic         evt_prev;
        logic [4:0]   trig_cnt;
        fault_state_t fst;
        drive_ctrl_t  drive;
        logic [15:0]  rdata;
        logic         irq;
        logic [8:0]   pos_mv;
        logic [8:0]   neg_mv;
        logic         gl_only;
    } top_state_t;

    // Threshold magnitude in millivolts for a trip level code.
    function automatic logic [8:0] trip_mv(input logic [3:0] code);
        case (code)
            4'h0:    trip_mv = 9'd300;
            4'h1:    trip_mv = 9'd250;
            4'h2:    trip_mv = 9'd225;
            4'h3:    trip_mv = 9'd200;
            4'h4:    trip_mv = 9'd175;
            4'h5:    trip_mv = 9'd150;
            4'h6:    trip_mv = 9'd125;
            4'h7:    trip_mv = 9'd100;
            4'h8:    trip_mv = 9'd90;
            4'h9:    trip_mv = 9'd80;
            4'hA:    trip_mv = 9'd70;
            4'hB:    trip_mv = 9'd60;
            4'hC:    trip_mv = 9'd50;
            4'hD:    trip_mv = 9'd40;
            4'hE:    trip_mv = 9'd30;
            default: trip_mv = 9'd20;
        endcase
    endfunction

    localparam prot_cfg_t RST_CFG  = prot_cfg_t'(`RST_PROT_CFG);
    localparam filt_cfg_t RST_FCFG = filt_cfg_t'(`RST_FILT_CFG);

    // Reset image of the top state.
    localparam top_state_t TOP_RESET = '{
        cfg:      RST_CFG,
        fcfg:     RST_FCFG,
        irq_en:   `RST_IRQ_EN,
        status:   3'h0,
        sync1:    6'h00,
        sync2:    6'h00,
        pos_prev: 1'b0,
        neg_prev: 1'b0,
        evt_prev: 1'b0,
        trig_cnt: 5'h00,
        fst:      FLT_IDLE,
        drive:    3'h0,
        rdata:    16'h0000,
        irq:      1'b0,
        pos_mv:   trip_mv(RST_CFG.positive_trip_level),
        neg_mv:   trip_mv(RST_CFG.negative_trip_level),
        gl_only:  RST_CFG.rdson_sensing
    };

endpackage

`default_nettype wire

/* File: rtl/trip_filter.sv */
// Glitch filter that passes a level once it has stood for a set number of cycles.
`default_nettype none
`include "sense_prot_consts.svh"

module trip_filter #(
    parameter int CNT_W = `FILT_CNT_W
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             level_in,
    input  wire logic             bypass,
    input  wire logic [CNT_W-1:0] hold_cycles,
    output logic                  level_out
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             out;
    } filt_state_t;

    filt_state_t st_r;
    filt_state_t st_nxt;

    // The longest hold time must fit the counter.
    if (CNT_W < `FILT_CNT_W) begin : g_bad_width
        $error("trip_filter counter too narrow for the longest filter time.");
    end

    // Count while the level stands; a drop restarts the wait.
    always_comb begin
        st_nxt = st_r;
        if (bypass || hold_cycles == '0) begin
            st_nxt.cnt = '0;
            st_nxt.out = level_in;
        end else if (!level_in) begin
            st_nxt.cnt = '0;
            st_nxt.out = 1'b0;
        end else if (st_r.cnt >= hold_cycles) begin
            st_nxt.out = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
            st_nxt.out = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_out = st_r.out;

endmodule // trip_filter

`default_nettype wire

/* File: rtl/sense_prot_regs.sv */
// Overcurrent protection configuration registers and fault control for three phases.
//
// Function
// - Positive trip level code in bits 3:0, 300 mV down to 20 mV.
// - Negative trip level code in bits 7:4, -300 mV up to -20 mV.
// - Bit 8 selects unlatched or latched overcurrent fault.
// - Bit 9 selects shunt or on-resistance sensing; latter forces low-side-gate timing.
// - Bit 10 brakes the motor on fault and forces the fault latched.
// - Bit 11 clear truncates PWM on overcurrent; set suppresses truncation.
// - Bit 13 removes negative protection: no truncation and no fault from it.
// - Bits 15:14 choose auto-zero sync mode and charge pump clock gating.
// - Register at address 1E, sixteen bits, resets to 0833 hex.
// - Glitch filter is bypassed while truncation is enabled.
// - Fault after 8 events, 16 events, every event, or never.
//
// The strobed register port was decided locally.
`default_nettype none
`include "sense_prot_consts.svh"

module sense_prot_regs
    import sense_prot_pkg::*;
#(
    parameter int FILT_W = `FILT_CNT_W
) (
    input  wire logic                         sys_clk,
    input  wire logic                         sys_rst,
    input  wire logic [7:0]                   reg_addr,
    input  wire logic [15:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic [15:0]                       reg_rdata,
    input  wire sense_prot_pkg::trip_t        trip_in,
    output sense_prot_pkg::drive_ctrl_t       drive_out,
    output logic [8:0]                        pos_trip_mv,
    output logic [8:0]                        neg_trip_mv,
    output logic                              low_side_gate_only,
    output logic                              sense_rdson,
    output sense_prot_pkg::auto_zero_t        auto_zero_mode,
    output logic                              cp_clk_gate,
    output logic                              reference_external,
    output logic                              irq
);

    import sense_prot_pkg::*;

    // ****************************************
    // Elaboration checks
    // ****************************************

    if (FILT_W < `FILT_CNT_W) begin : g_bad_width
        $error("sense_prot_regs filter counter too narrow.");
    end

    // ****************************************
    // State and helpers
    // ****************************************

    top_state_t        st_r;
    top_state_t        st_nxt;
    logic [2:0]        filt_out;
    logic [2:0]        pos_q;
    logic [2:0]        neg_q;
    logic [FILT_W-1:0] hold_cycles;
    logic              filt_bypass;

    // Hold time in cycles for a filter time code.
    function automatic logic [FILT_W-1:0] filter_cycles(input logic [1:0] code);
        case (code)
            2'h0:    filter_cycles = FILT_W'(`FILT_T0_CYC);
            2'h1:    filter_cycles = FILT_W'(`FILT_T1_CYC);
            2'h2:    filter_cycles = FILT_W'(`FILT_T2_CYC);
            default: filter_cycles = FILT_W'(`FILT_T3_CYC);
        endcase
    endfunction

    // Trips after synchronising, gated by phase enable and negative disable.
    assign pos_q = st_r.sync2.pos & st_r.fcfg.phase_enable;
    assign neg_q = st_r.sync2.neg & st_r.fcfg.phase_enable
                 & {3{~st_r.cfg.negative_protection_disable}};

    // Filter stands aside while truncation is active.
    assign filt_bypass = ~st_r.cfg.truncation_disable;
    assign hold_cycles = filter_cycles(st_r.fcfg.overcurrent_filter_time);

    // ****************************************
    // Per-phase glitch filters
    // ****************************************

    // One filter per phase, all fed the same hold time.
    for (genvar i = 0; i < 3; i++) begin : g_phase
        trip_filter #(
            .CNT_W       (FILT_W)
        ) u_filter (
            .sys_clk     (sys_clk),
            .sys_rst     (sys_rst),
            .level_in    (pos_q[i] | neg_q[i]),
            .bypass      (filt_bypass),
            .hold_cycles (hold_cycles),
            .level_out   (filt_out[i])
        );
    end

    // ****************************************
    // Next state
    // ****************************************

    // Bus access, event counting, fault state and outputs.
    always_comb begin
        logic       pos_rise;
        logic       neg_rise;
        logic       evt;
        logic       evt_rise;
        logic       trig_hit;
        logic       hold_fault;
        logic [2:0] clr;
        logic [2:0] set;
        pos_rise   = 1'b0;
        neg_rise   = 1'b0;
        evt        = 1'b0;
        evt_rise   = 1'b0;
        trig_hit   = 1'b0;
        hold_fault = 1'b0;
        clr        = 3'h0;
        set        = 3'h0;
        st_nxt     = st_r;

        // Two-stage synchroniser for the comparator pins.
        st_nxt.sync1 = trip_in;
        st_nxt.sync2 = st_r.sync1;

        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_PROT_CFG: st_nxt.cfg    = prot_cfg_t'(reg_wdata);
                `ADDR_FILT_CFG: st_nxt.fcfg   = filt_cfg_t'(reg_wdata[6:0]);
                `ADDR_IRQ_EN:   st_nxt.irq_en = reg_wdata[2:0];
                `ADDR_CLEAR:    clr           = reg_wdata[2:0];
                default:        ;
            endcase
        end

        // Qualified trip edges for the sticky status bits.
        pos_rise        = (|pos_q) & ~st_r.pos_prev;
        neg_rise        = (|neg_q) & ~st_r.neg_prev;
        st_nxt.pos_prev = |pos_q;
        st_nxt.neg_prev = |neg_q;

        // Filtered event drives fault counting, whatever truncation does.
        evt             = |filt_out;
        evt_rise        = evt & ~st_r.evt_prev;
        st_nxt.evt_prev = evt;

        // Event counting by trigger policy.
        case (st_r.fcfg.overcurrent_trigger_count)
            TRIG_8: begin
                if (evt_rise) begin
                    if (st_r.trig_cnt >= 5'(`TRIG_CNT_A - 1)) begin
                        trig_hit        = 1'b1;
                        st_nxt.trig_cnt = 5'h00;
                    end else begin
                        st_nxt.trig_cnt = st_r.trig_cnt + 5'h01;
                    end
                end
            end
            TRIG_16: begin
                if (evt_rise) begin
                    if (st_r.trig_cnt >= 5'(`TRIG_CNT_B - 1)) begin
                        trig_hit        = 1'b1;
                        st_nxt.trig_cnt = 5'h00;
                    end else begin
                        st_nxt.trig_cnt = st_r.trig_cnt + 5'h01;
                    end
                end
            end
            TRIG_ALL: begin
                trig_hit        = evt_rise;
                st_nxt.trig_cnt = 5'h00;
            end
            default: begin
                st_nxt.trig_cnt = 5'h00;
            end
        endcase

        // Brake forces the fault to hold.
        hold_fault = st_r.cfg.overcurrent_fault_hold
                   | st_r.cfg.brake_on_overcurrent;

        // Fault state: unlatched follows the event, held waits for a clear.
        case (st_r.fst)
            FLT_IDLE: begin
                if (trig_hit) begin
                    st_nxt.fst = hold_fault ? FLT_HELD : FLT_ACTIVE;
                end
            end
            FLT_ACTIVE: begin
                if (hold_fault) begin
                    st_nxt.fst = FLT_HELD;
                end else if (!evt) begin
                    st_nxt.fst = FLT_IDLE;
                end
            end
            FLT_HELD: begin
                if (clr[`STAT_FAULT_BIT] && !trig_hit) begin
                    st_nxt.fst = FLT_IDLE;
                end
            end
            default: begin
                st_nxt.fst = FLT_IDLE;
            end
        endcase

        // Sticky status; a new event beats a clear in the same cycle.
        set[`STAT_FAULT_BIT] = trig_hit;
        set[`STAT_POS_BIT]   = pos_rise;
        set[`STAT_NEG_BIT]   = neg_rise;
        st_nxt.status        = (st_r.status & ~clr) | set;
        st_nxt.irq           = |(st_nxt.status & st_nxt.irq_en);

        // Drive controls.
        st_nxt.drive.fault    = (st_nxt.fst != FLT_IDLE);
        st_nxt.drive.truncate = ~st_r.cfg.truncation_disable
                              & (|(pos_q | neg_q));
        st_nxt.drive.brake    = st_nxt.drive.fault
                              & st_r.cfg.brake_on_overcurrent;

        // Decoded configuration outputs.
        st_nxt.pos_mv  = trip_mv(st_nxt.cfg.positive_trip_level);
        st_nxt.neg_mv  = trip_mv(st_nxt.cfg.negative_trip_level);
        st_nxt.gl_only = st_nxt.cfg.rdson_sensing;

        // Read data stand for one cycle only.
        st_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_PROT_CFG: st_nxt.rdata = st_r.cfg;
                `ADDR_FILT_CFG: st_nxt.rdata = {9'h000, st_r.fcfg};
                `ADDR_STATUS:   st_nxt.rdata = {13'h0000, st_r.status};
                `ADDR_IRQ_EN:   st_nxt.rdata = {13'h0000, st_r.irq_en};
                `ADDR_LIVE:     st_nxt.rdata = {11'h000, st_r.fst, st_r.drive};
                default:        st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************

    // All state moves on every edge; reset loads the documented image.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= TOP_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************

    // Every output is a field of the state register, except cp_clk_gate, which is decoded from auto_zero_select.
    assign reg_rdata          = st_r.rdata;
    assign drive_out          = st_r.drive;
    assign pos_trip_mv        = st_r.pos_mv;
    assign neg_trip_mv        = st_r.neg_mv;
    assign low_side_gate_only = st_r.gl_only;
    assign sense_rdson        = st_r.cfg.rdson_sensing;
    assign auto_zero_mode     = st_r.cfg.auto_zero_select;
    assign cp_clk_gate        = (st_r.cfg.auto_zero_select == AZ_EXT_CP_GATE);
    assign reference_external = st_r.cfg.reference_source_select;
    assign irq                = st_r.irq;

endmodule // sense_prot_regs

`default_nettype wire

/* File: sim/sense_prot_regs_asserts.sv */
// Concurrent checks on the ports of the protection register block.
`default_nettype none

module sense_prot_regs_asserts #(
    parameter int FILT_W = 10
) (
    input wire logic                        sys_clk,
    input wire logic                        sys_rst,
    input wire logic [7:0]                  reg_addr,
    input wire logic [15:0]                 reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [15:0]                 reg_rdata,
    input wire sense_prot_pkg::trip_t       trip_in,
    input wire sense_prot_pkg::drive_ctrl_t drive_out,
    input wire logic [8:0]                  pos_trip_mv,
    input wire logic [8:0]                  neg_trip_mv,
    input wire logic                        low_side_gate_only,
    input wire logic                        sense_rdson,
    input wire sense_prot_pkg::auto_zero_t  auto_zero_mode,
    input wire logic                        cp_clk_gate,
    input wire logic                        reference_external,
    input wire logic                        irq
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [15:0] cfg_r;
    logic [6:0]  fcfg_r;

    // Mirrors software writes.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_r  <= 16'h0833;
            fcfg_r <= 7'h07;
        end else if (reg_wr && reg_addr == 8'h1E) begin
            cfg_r <= reg_wdata;
        end else if (reg_wr && reg_addr == 8'h20) begin
            fcfg_r <= reg_wdata[6:0];
        end
    end

    property p_thr;
        cfg_r[7:0] == 8'hF0 |-> pos_trip_mv == 9'h12C && neg_trip_mv == 9'h014;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold decode wrong");
    property p_gl;
        low_side_gate_only == cfg_r[9] && sense_rdson == cfg_r[9];
    endproperty
    a_gl: assert property (p_gl) else $error("sensing mode wrong");
    property p_az;
        auto_zero_mode == cfg_r[15:14] && cp_clk_gate == &cfg_r[15:14];
    endproperty
    a_az: assert property (p_az) else $error("auto zero mode wrong");
    property p_readback;
        reg_rd && reg_addr == 8'h1E |=> reg_rdata == $past(cfg_r);
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");
    property p_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_trunc_off;
        cfg_r[11] |=> !drive_out.truncate;
    endproperty
    a_trunc_off: assert property (p_trunc_off) else $error("truncation not off");
    property p_trunc_lat;
        $rose(trip_in.pos[0]) && !cfg_r[11] && fcfg_r[0] |-> ##3 drive_out.truncate;
    endproperty
    a_trunc_lat: assert property (p_trunc_lat) else $error("truncation late");
    property p_neg_off;
        (cfg_r[13] && trip_in.pos == 3'h0) [*3] |=> !drive_out.truncate;
    endproperty
    a_neg_off: assert property (p_neg_off) else $error("negative trip acted");
    property p_latch;
        drive_out.fault && (cfg_r[8] || cfg_r[10]) && !(reg_wr && reg_addr == 8'h22)
            |=> drive_out.fault;
    endproperty
    a_latch: assert property (p_latch) else $error("held fault dropped");
    property p_brake;
        $rose(drive_out.fault) |-> drive_out.brake == cfg_r[10];
    endproperty
    a_brake: assert property (p_brake) else $error("brake wrong");
    property p_none;
        fcfg_r[6:5] == 2'b11 |=> !$rose(drive_out.fault);
    endproperty
    a_none: assert property (p_none) else $error("fault with trigger off");

endmodule // sense_prot_regs_asserts

bind sense_prot_regs sense_prot_regs_asserts #(.FILT_W(FILT_W)) chk_u (.*);

`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for the protection register block.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sense_prot_pkg::*;

    typedef struct packed {
        logic [15:0] wd;
        logic [8:0]  pmv;
        logic [8:0]  nmv;
    } row_t;

    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    trip_t       trip_in = '0;
    drive_ctrl_t drive_out;
    logic [8:0]  pos_trip_mv;
    logic [8:0]  neg_trip_mv;
    logic        low_side_gate_only;
    logic        sense_rdson;
    auto_zero_t  auto_zero_mode;
    logic        cp_clk_gate;
    logic        reference_external;
    logic        irq;
    logic [15:0] rd_q;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    // Words beside the magnitudes they give.
    row_t rows [16] = '{
        '{16'h00F0, 9'h12C, 9'h14}, '{16'h42E1, 9'hFA, 9'h1E}, '{16'h80D2, 9'hE1, 9'h28},
        '{16'hC2C3, 9'hC8, 9'h32}, '{16'h20B4, 9'hAF, 9'h3C}, '{16'h62A5, 9'h96, 9'h46},
        '{16'hA096, 9'h7D, 9'h50}, '{16'hE287, 9'h64, 9'h5A}, '{16'h0878, 9'h5A, 9'h64},
        '{16'h4A69, 9'h50, 9'h7D}, '{16'h845A, 9'h46, 9'h96}, '{16'hCE4B, 9'h3C, 9'hAF},
        '{16'h013C, 9'h32, 9'hC8}, '{16'h432D, 9'h28, 9'hE1}, '{16'h821E, 9'h1E, 9'hFA},
        '{16'hC70F, 9'h14, 9'h12C}};

    sense_prot_regs dut_u (.*);

    // 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    // Run ceiling.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("Error: timeout expected end seen hang");
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error: %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle; read data taken in the cycle after.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d = 16'h0000);
        @(posedge sys_clk);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        rd_q = reg_rdata;
    endtask

    task automatic cfg(input logic [15:0] c, input logic [6:0] f);
        bus(1'b1, 8'h1E, c);
        bus(1'b1, 8'h20, {9'h000, f});
    endtask

    // Holds a trip and checks truncation and fault.
    task automatic trip_chk(input logic [5:0] t, input logic et, ef, eh);
        @(posedge sys_clk);
        trip_in <= trip_t'(t);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("truncate", et, drive_out.truncate);
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("fault", ef, drive_out.fault);
        @(posedge sys_clk);
        trip_in <= '0;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("fault_after", eh, drive_out.fault);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            trip_in <= trip_t'(6'h08);
            repeat (6) @(posedge sys_clk);
            trip_in <= '0;
            repeat (6) @(posedge sys_clk);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // Table of words and decoded outputs.
        foreach (rows[i]) begin
            bus(1'b1, 8'h1E, rows[i].wd);
            chk("pos_trip_mv", rows[i].pmv, pos_trip_mv);
            chk("neg_trip_mv", rows[i].nmv, neg_trip_mv);
            chk("gl_only", rows[i].wd[9], low_side_gate_only);
            chk("az_mode", rows[i].wd[15:14], auto_zero_mode);
            chk("cp_gate", &rows[i].wd[15:14], cp_clk_gate);
            chk("ref_ext", rows[i].wd[12], reference_external);
            bus(1'b0, 8'h1E);
            chk("readback", rows[i].wd, rd_q);
        end
        $display("Test table done");
        // Mid-run reset, then unmapped access.
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        chk("pos_reset", 16'h00C8, pos_trip_mv);
        chk("neg_reset", 16'h00C8, neg_trip_mv);
        bus(1'b0, 8'h1E);
        chk("cfg_reset", 16'h0833, rd_q);
        bus(1'b1, 8'h10, 16'hFFFF);
        bus(1'b0, 8'h10);
        chk("unmapped", 16'h0000, rd_q);
        bus(1'b0, 8'h1E);
        chk("cfg_kept", 16'h0833, rd_q);
        $display("Test reset done");
        // Phase enables, negative disable and truncation disable.
        cfg(16'h0033, 7'h46);
        trip_chk(6'h08, 1'b0, 1'b0, 1'b0);
        trip_chk(6'h20, 1'b1, 1'b1, 1'b0);
        trip_chk(6'h02, 1'b1, 1'b1, 1'b0);
        cfg(16'h2033, 7'h46);
        trip_chk(6'h02, 1'b0, 1'b0, 1'b0);
        cfg(16'h0833, 7'h47);
        trip_chk(6'h08, 1'b0, 1'b1, 1'b0);
        // Short trip filtered only with truncation off.
        cfg(16'h0833, 7'h4F);
        @(posedge sys_clk);
        trip_in <= trip_t'(6'h08);
        repeat (100) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("filtered", 1'b0, drive_out.fault);
        @(posedge sys_clk);
        trip_in <= '0;
        cfg(16'h0033, 7'h4F);
        trip_chk(6'h08, 1'b1, 1'b1, 1'b0);
        $display("Test truncation done");
        // Latched fault, brake, and clear.
        cfg(16'h0133, 7'h47);
        trip_chk(6'h08, 1'b1, 1'b1, 1'b1);
        bus(1'b1, 8'h22, 16'h0001);
        chk("fault_clear", 1'b0, drive_out.fault);
        cfg(16'h0433, 7'h47);
        trip_chk(6'h08, 1'b1, 1'b1, 1'b1);
        chk("brake", 1'b1, drive_out.brake);
        bus(1'b1, 8'h22, 16'h0001);
        chk("brake_clear", 1'b0, drive_out.brake);
        $display("Test latch done");
        // Counts of eight and sixteen, then no trigger.
        bus(1'b1, 8'h1E, 16'h0133);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, 8'h20, k ? 16'h0027 : 16'h0007);
            pulse(k ? 15 : 7);
            chk("count_short", 1'b0, drive_out.fault);
            pulse(1);
            chk("count_full", 1'b1, drive_out.fault);
            bus(1'b1, 8'h22, 16'h0001);
        end
        bus(1'b1, 8'h20, 16'h0067);
        pulse(20);
        chk("no_trigger", 1'b0, drive_out.fault);
        $display("Test count done");
        // Interrupt on the positive edge bit; the fault bit was cleared last.
        bus(1'b0, 8'h21);
        chk("status", 16'h0006, rd_q);
        chk("irq_off", 1'b0, irq);
        bus(1'b1, 8'h23, 16'h0002);
        chk("irq_on", 1'b1, irq);
        bus(1'b1, 8'h23, 16'h0000);
        chk("irq_mask", 1'b0, irq);
        bus(1'b1, 8'h23, 16'h0002);
        bus(1'b1, 8'h22, 16'h0007);
        chk("irq_clear", 1'b0, irq);
        bus(1'b0, 8'h21);
        chk("status_clear", 16'h0000, rd_q);
        $display("Test interrupt done");
        print_verdict();
    end

endmodule // testbench

`default_nettype wire
